// ---- common/dcm_pkg.sv ----
// shared constants, command codes and carriers for the dram command block
// assumes a single 10 MHz clock and one beat per clock inside the block
package dcm_pkg;
  localparam int BANK_W = 3;
  localparam int ROW_W = 4;
  localparam int COL_W = 4;
  localparam int ADDR_W = 14;
  localparam int DATA_W = 8;
  localparam int NBANK = 8;
  localparam int MR_W = 17;
  localparam int PIPE_DEPTH = 16;
  localparam int FIFO_DEPTH = 16;
  localparam int MEM_WORDS = NBANK * (1 << ROW_W) * (1 << COL_W);

  localparam logic [MR_W-1:0] MR_RESET = 17'h00032;
  localparam logic [MR_W-1:0] EMR_RESET = 17'h00000;
  localparam int MR_BL_LSB = 0;
  localparam int MR_BT_BIT = 3;
  localparam int MR_CL_LSB = 4;
  localparam int MR_DLLRST_BIT = 8;
  localparam int MR_WR_LSB = 9;
  localparam int EMR_AL_LSB = 3;
  localparam int AUTO_PRE_BIT = 10;
  localparam logic [2:0] BL8_CODE = 3'h3;
  localparam logic [1:0] BA_SEL_MR = 2'h0;
  localparam logic [1:0] BA_SEL_EMR = 2'h1;

  localparam int CLK_PERIOD_NS = 100;
  localparam int PRECHARGE_NS = 15;
  localparam int PRECHARGE_RAW = (PRECHARGE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] PRECHARGE_CYC = 4'((PRECHARGE_RAW < 1) ? 1 : PRECHARGE_RAW);
  localparam logic [7:0] DLL_LOCK_CYC = 8'hC8;

  // {cs_b, ras_b, cas_b, we_b}
  typedef enum logic [3:0] {
    CMD_LOAD_MODE = 4'h0,
    CMD_REFRESH = 4'h1,
    CMD_PRECHARGE = 4'h2,
    CMD_ACTIVATE = 4'h3,
    CMD_WRITE = 4'h4,
    CMD_READ = 4'h5,
    CMD_NOP = 4'h7
  } dcm_cmd_t;

  typedef enum logic [1:0] {
    BURST_IDLE = 2'h0,
    BURST_READ = 2'h1,
    BURST_WRITE = 2'h3
  } dcm_burst_t;

  typedef struct packed {
    logic cke;
    logic cs_b;
    logic ras_b;
    logic cas_b;
    logic we_b;
    logic [BANK_W-1:0] ba;
    logic [ADDR_W-1:0] a;
  } dcm_pins_t;

  typedef struct packed {
    logic valid;
    logic wr;
    logic ap;
    logic [BANK_W-1:0] ba;
    logic [COL_W-1:0] col;
  } dcm_col_cmd_t;
endpackage

// ---- rtl/dcm_fifo.sv ----
// synchronous fifo with valid/ready on both sides
// assumes one clock; full and empty come from wrap-bit pointers
`timescale 1ns/1ps
`default_nettype none
module dcm_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  input wire logic [WIDTH-1:0] in_data_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  output logic [WIDTH-1:0] out_data_o,
  output logic out_valid_o,
  input wire logic out_ready_i
);
  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [PW:0] wr_ptr_r;
  logic [PW:0] rd_ptr_r;
  logic push;
  logic pop;

  assign in_ready_o = !((wr_ptr_r[PW] != rd_ptr_r[PW]) && (wr_ptr_r[PW-1:0] == rd_ptr_r[PW-1:0]));
  assign out_valid_o = (wr_ptr_r != rd_ptr_r);
  assign out_data_o = mem_r[rd_ptr_r[PW-1:0]];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  always_ff @(posedge sys_clk_i)
  begin
    if (push)
    begin
      mem_r[wr_ptr_r[PW-1:0]] <= in_data_i;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr_r <= wr_ptr_r + (PW+1)'(1);
      end
      if (pop)
      begin
        rd_ptr_r <= rd_ptr_r + (PW+1)'(1);
      end
    end
  end
endmodule
`default_nettype wire

// ---- rtl/dcm_dram_core.sv ----
// command decode, mode register, bank state and burst engine of a dram device
// assumes pins are synchronous to sys_clk_i and the controller keeps its timing
`timescale 1ns/1ps
`default_nettype none
module dcm_dram_core
  import dcm_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  input wire dcm_pkg::dcm_pins_t pins_i,
  input wire logic [dcm_pkg::DATA_W-1:0] wr_data_i,
  input wire logic wr_mask_i,
  output logic wr_beat_o,
  output logic [dcm_pkg::DATA_W-1:0] rd_data_o,
  output logic rd_valid_o,
  input wire logic rd_ready_i,
  output logic [dcm_pkg::NBANK-1:0] bank_open_o,
  output logic [dcm_pkg::NBANK-1:0] bank_precharging_o,
  output logic self_refresh_o,
  output logic dll_on_o,
  output logic dll_locked_o,
  output logic [dcm_pkg::ROW_W-1:0] refresh_row_o
);
  import dcm_pkg::*;

  logic [MR_W-1:0] mode_r;
  logic [MR_W-1:0] ext_mode_r;
  logic self_ref_r;
  logic [7:0] dll_cnt_r;
  logic [ROW_W-1:0] refresh_row_r;
  logic [NBANK-1:0] open_r;
  logic [ROW_W-1:0] row_r [NBANK];
  logic [3:0] pre_cnt_r [NBANK];
  dcm_col_cmd_t pipe_r [PIPE_DEPTH];
  dcm_burst_t state_r;
  logic [2:0] beat_r;
  logic [COL_W-1:0] start_col_r;
  logic [BANK_W-1:0] bank_r;
  logic ap_r;
  logic bl8_r;
  logic ilv_r;
  logic [3:0] wr_ap_cnt_r;
  logic [BANK_W-1:0] wr_ap_bank_r;
  logic [DATA_W-1:0] mem_r [MEM_WORDS];

  dcm_cmd_t cmd;
  logic selected;
  logic cmd_ok;
  logic sr_enter;
  logic sr_exit;
  logic [2:0] cl;
  logic [2:0] al;
  logic [3:0] rd_tap;
  logic [3:0] wr_tap;
  logic launch_rd;
  logic launch_wr;
  dcm_col_cmd_t launch;
  logic [COL_W-1:0] beat_col;
  logic [ROW_W+COL_W+BANK_W-1:0] beat_idx;
  logic fifo_in_ready;
  logic rd_push;
  logic last_beat;
  logic [NBANK-1:0] pre_mask;
  dcm_col_cmd_t new_cmd;

  // column of beat k inside the aligned block
  function automatic logic [COL_W-1:0] burst_col(
    input logic [COL_W-1:0] start,
    input logic [2:0] k,
    input logic ilv
  );
    logic [2:0] lo;
    lo = '0;
    if (ilv)
    begin
      lo = start[2:0] ^ k;
    end
    else
    begin
      lo = {start[2] ^ k[2], start[1:0] + k[1:0]};
    end
    return {start[COL_W-1:3], lo};
  endfunction

  // decode: chip select high or clock enable low gives no command, except refresh with clock enable low, which enters self refresh
  assign cmd = dcm_cmd_t'({pins_i.cs_b, pins_i.ras_b, pins_i.cas_b, pins_i.we_b});
  assign selected = !pins_i.cs_b;
  assign cmd_ok = selected && pins_i.cke && !self_ref_r;
  assign sr_enter = selected && !pins_i.cke && !self_ref_r && (cmd == CMD_REFRESH);
  assign sr_exit = self_ref_r && pins_i.cke;

  assign cl = mode_r[MR_CL_LSB +: 3];
  assign al = ext_mode_r[EMR_AL_LSB +: 3];
  assign rd_tap = 4'({1'b0, al}) + 4'({1'b0, cl}) - 4'h1;
  assign wr_tap = 4'({1'b0, al}) + 4'({1'b0, cl}) - 4'h2;
  assign launch_rd = pipe_r[rd_tap].valid && !pipe_r[rd_tap].wr;
  assign launch_wr = pipe_r[wr_tap].valid && pipe_r[wr_tap].wr;
  assign launch = launch_rd ? pipe_r[rd_tap] : pipe_r[wr_tap];

  always_comb
  begin
    new_cmd = '0;
    if (cmd_ok && ((cmd == CMD_READ) || (cmd == CMD_WRITE)))
    begin
      new_cmd.valid = 1'b1;
      new_cmd.wr = (cmd == CMD_WRITE);
      new_cmd.ap = pins_i.a[AUTO_PRE_BIT];
      new_cmd.ba = pins_i.ba;
      new_cmd.col = pins_i.a[COL_W-1:0];
    end
  end

  assign beat_col = burst_col(start_col_r, beat_r, ilv_r);
  assign beat_idx = {bank_r, row_r[bank_r], beat_col};
  assign last_beat = (beat_r == (bl8_r ? 3'h7 : 3'h3));
  assign rd_push = (state_r == BURST_READ);
  assign wr_beat_o = (state_r == BURST_WRITE);

  // precharge sources: command, read auto precharge, write recovery expiry
  always_comb
  begin
    pre_mask = '0;
    if (cmd_ok && (cmd == CMD_PRECHARGE))
    begin
      if (pins_i.a[AUTO_PRE_BIT])
      begin
        pre_mask = '1;
      end
      else
      begin
        pre_mask[pins_i.ba] = 1'b1;
      end
    end
    if (rd_push && fifo_in_ready && last_beat && ap_r)
    begin
      pre_mask[bank_r] = 1'b1;
    end
    if (wr_ap_cnt_r == 4'h1)
    begin
      pre_mask[wr_ap_bank_r] = 1'b1;
    end
  end

  // mode registers
  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      mode_r <= MR_RESET;
      ext_mode_r <= EMR_RESET;
    end
    else
    begin
      mode_r[MR_DLLRST_BIT] <= 1'b0;
      if (cmd_ok && (cmd == CMD_LOAD_MODE))
      begin
        if (pins_i.ba[1:0] == BA_SEL_MR)
        begin
          mode_r <= {pins_i.ba[2], 2'h0, pins_i.a};
        end
        else if (pins_i.ba[1:0] == BA_SEL_EMR)
        begin
          ext_mode_r <= {pins_i.ba[2], 2'h0, pins_i.a};
        end
      end
    end
  end

  // self refresh and delay-locked loop
  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      self_ref_r <= 1'b0;
      dll_cnt_r <= DLL_LOCK_CYC;
    end
    else
    begin
      if (sr_enter)
      begin
        self_ref_r <= 1'b1;
      end
      else if (sr_exit)
      begin
        self_ref_r <= 1'b0;
      end
      if (sr_exit || (mode_r[MR_DLLRST_BIT]))
      begin
        dll_cnt_r <= DLL_LOCK_CYC;
      end
      else if (!self_ref_r && (dll_cnt_r != 8'h00))
      begin
        dll_cnt_r <= dll_cnt_r - 8'h01;
      end
    end
  end

  assign self_refresh_o = self_ref_r;
  assign dll_on_o = !self_ref_r;
  assign dll_locked_o = !self_ref_r && (dll_cnt_r == 8'h00);

  // internal refresh row counter, address pins unused
  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      refresh_row_r <= '0;
    end
    else if ((cmd_ok && (cmd == CMD_REFRESH)) || sr_enter)
    begin
      refresh_row_r <= refresh_row_r + ROW_W'(1);
    end
  end

  assign refresh_row_o = refresh_row_r;

  // per-bank open row and precharge timer
  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      open_r <= '0;
      for (int i = 0; i < NBANK; i++)
      begin
        row_r[i] <= '0;
        pre_cnt_r[i] <= '0;
      end
    end
    else
    begin
      for (int i = 0; i < NBANK; i++)
      begin
        if (pre_mask[i])
        begin
          open_r[i] <= 1'b0;
          pre_cnt_r[i] <= PRECHARGE_CYC;
        end
        else
        begin
          if (pre_cnt_r[i] != 4'h0)
          begin
            pre_cnt_r[i] <= pre_cnt_r[i] - 4'h1;
          end
          if (cmd_ok && (cmd == CMD_ACTIVATE) && (pins_i.ba == BANK_W'(i)))
          begin
            open_r[i] <= 1'b1;
            row_r[i] <= pins_i.a[ROW_W-1:0];
          end
        end
      end
    end
  end

  assign bank_open_o = open_r;

  always_comb
  begin
    for (int i = 0; i < NBANK; i++)
    begin
      bank_precharging_o[i] = (pre_cnt_r[i] != 4'h0);
    end
  end

  // latency line for column commands
  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      for (int i = 0; i < PIPE_DEPTH; i++)
      begin
        pipe_r[i] <= '0;
      end
    end
    else
    begin
      pipe_r[0] <= new_cmd;
      for (int i = 1; i < PIPE_DEPTH; i++)
      begin
        pipe_r[i] <= pipe_r[i-1];
      end
    end
  end

  // burst engine: one beat per clock, reads stall on a full fifo
  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      state_r <= BURST_IDLE;
      beat_r <= '0;
      start_col_r <= '0;
      bank_r <= '0;
      ap_r <= 1'b0;
      bl8_r <= 1'b0;
      ilv_r <= 1'b0;
    end
    else if (launch_rd || launch_wr)
    begin
      state_r <= launch_rd ? BURST_READ : BURST_WRITE;
      beat_r <= '0;
      start_col_r <= launch.col;
      bank_r <= launch.ba;
      ap_r <= launch.ap;
      bl8_r <= (mode_r[MR_BL_LSB +: 3] == BL8_CODE);
      ilv_r <= mode_r[MR_BT_BIT];
    end
    else
    begin
      unique case (state_r)
        BURST_IDLE:
        begin
          beat_r <= '0;
        end
        BURST_READ:
        begin
          if (fifo_in_ready)
          begin
            beat_r <= beat_r + 3'h1;
            if (last_beat)
            begin
              state_r <= BURST_IDLE;
            end
          end
        end
        BURST_WRITE:
        begin
          beat_r <= beat_r + 3'h1;
          if (last_beat)
          begin
            state_r <= BURST_IDLE;
          end
        end
        default:
        begin
          state_r <= BURST_IDLE;
        end
      endcase
    end
  end

  // write recovery wait before auto precharge
  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      wr_ap_cnt_r <= '0;
      wr_ap_bank_r <= '0;
    end
    else if (wr_beat_o && last_beat && ap_r && !launch_rd && !launch_wr)
    begin
      wr_ap_cnt_r <= 4'({1'b0, mode_r[MR_WR_LSB +: 3]}) + 4'h1;
      wr_ap_bank_r <= bank_r;
    end
    else if (wr_ap_cnt_r != 4'h0)
    begin
      wr_ap_cnt_r <= wr_ap_cnt_r - 4'h1;
    end
  end

  // array write; load mode never touches it
  always_ff @(posedge sys_clk_i)
  begin
    if (wr_beat_o && !wr_mask_i)
    begin
      mem_r[beat_idx] <= wr_data_i;
    end
  end

  dcm_fifo #(
    .WIDTH(DATA_W),
    .DEPTH(FIFO_DEPTH)
  ) u_rd_fifo (
    .sys_clk_i(sys_clk_i),
    .rst_b_i(rst_b_i),
    .in_data_i(mem_r[beat_idx]),
    .in_valid_i(rd_push),
    .in_ready_o(fifo_in_ready),
    .out_data_o(rd_data_o),
    .out_valid_o(rd_valid_o),
    .out_ready_i(rd_ready_i)
  );
endmodule
`default_nettype wire

// ---- sim/dcm_dram_core_checker.sv ----
// port assertions for the dram command block
// bound into every dcm_dram_core instance
`timescale 1ns/1ps
`default_nettype none
module dcm_dram_core_checker (
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  input wire dcm_pkg::dcm_pins_t pins_i,
  input wire logic wr_beat_o,
  input wire logic [dcm_pkg::NBANK-1:0] bank_open_o,
  input wire logic [dcm_pkg::NBANK-1:0] bank_precharging_o,
  input wire logic self_refresh_o,
  input wire logic dll_on_o,
  input wire logic dll_locked_o,
  input wire logic [dcm_pkg::ROW_W-1:0] refresh_row_o
);
  import dcm_pkg::*;
  logic go;
  logic [3:0] cmd;
  assign go = !pins_i.cs_b && pins_i.cke && !self_refresh_o;
  assign cmd = {pins_i.cs_b, pins_i.ras_b, pins_i.cas_b, pins_i.we_b};
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rst_b_i);
  a_act_opens_bank: assert property (go && cmd == CMD_ACTIVATE |=> bank_open_o[$past(pins_i.ba)])
    else $error("activate did not open its bank");
  a_pre_closes_bank: assert property (go && cmd == CMD_PRECHARGE && !pins_i.a[AUTO_PRE_BIT]
    |=> !bank_open_o[$past(pins_i.ba)] && bank_precharging_o[$past(pins_i.ba)])
    else $error("precharge did not close its bank");
  a_pre_all_banks: assert property (go && cmd == CMD_PRECHARGE && pins_i.a[AUTO_PRE_BIT] |=> bank_open_o == '0)
    else $error("precharge all left a bank open");
  a_refresh_row_step: assert property (go && cmd == CMD_REFRESH |=> refresh_row_o == $past(refresh_row_o) + 4'h1)
    else $error("refresh row did not advance");
  a_sr_entry: assert property (!pins_i.cs_b && !pins_i.cke && !self_refresh_o && cmd == CMD_REFRESH |=> self_refresh_o)
    else $error("self refresh not entered");
  a_sr_hold: assert property (self_refresh_o && !pins_i.cke |=> self_refresh_o)
    else $error("self refresh left with clock enable low");
  a_dll_follows_sr: assert property (dll_on_o == !self_refresh_o)
    else $error("dll state does not follow self refresh");
  a_dll_relock: assert property ($fell(self_refresh_o) |-> !dll_locked_o [*8])
    else $error("dll locked too soon after self refresh exit");
  a_idle_no_open: assert property (pins_i.cs_b || cmd == CMD_NOP |=> (bank_open_o & ~$past(bank_open_o)) == '0)
    else $error("bank opened without an activate");
  a_wr_beat_run: assert property ($rose(wr_beat_o) |-> wr_beat_o [*4])
    else $error("write burst shorter than four beats");
  c_write: cover property ($rose(wr_beat_o));
  c_self_refresh: cover property ($rose(self_refresh_o));
  c_precharge: cover property (go && cmd == CMD_PRECHARGE);
endmodule
bind dcm_dram_core dcm_dram_core_checker dcm_dram_core_checker_i (.sys_clk_i, .rst_b_i, .pins_i, .wr_beat_o,
  .bank_open_o, .bank_precharging_o, .self_refresh_o, .dll_on_o, .dll_locked_o, .refresh_row_o);
`default_nettype wire

// ---- sim/dcm_ctl_model.sv ----
// memory controller model: command pins, write data, read drain
// assumes the device samples its pins on rising clock edges
`timescale 1ns/1ps
`default_nettype none
module dcm_ctl_model (
  input wire logic sys_clk_i,
  output dcm_pkg::dcm_pins_t pins_o,
  output logic [dcm_pkg::DATA_W-1:0] wr_data_o,
  output logic wr_mask_o,
  input wire logic wr_beat_i,
  input wire logic [dcm_pkg::DATA_W-1:0] rd_data_i,
  input wire logic rd_valid_i,
  output logic rd_ready_o
);
  import dcm_pkg::*;
  logic cke_idle = 1'b1;
  logic [DATA_W-1:0] wq[$];
  logic mq[$];
  logic [DATA_W-1:0] rq[$];
  initial
  begin
    pins_o = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 3'h0, 14'h0000};
    wr_data_o = '0;
    wr_mask_o = 1'b1;
    rd_ready_o = 1'b0;
  end
  // one command edge, then a nop with unsampled address lines toggled
  task automatic issue(input logic [3:0] c, input logic [2:0] b, input logic [13:0] a);
    @(posedge sys_clk_i);
    #1;
    pins_o = '{cke_idle, c[3], c[2], c[1], c[0], b, a};
    @(posedge sys_clk_i);
    #1;
    pins_o = '{cke_idle, 1'b0, 1'b1, 1'b1, 1'b1, ~b, ~a};
  endtask
  always @(posedge sys_clk_i)
  begin
    #1;
    if (wr_beat_i && wq.size() > 0)
    begin
      wr_data_o = wq.pop_front();
      wr_mask_o = mq.pop_front();
    end
    else
    begin
      wr_data_o = ~wr_data_o;
      wr_mask_o = 1'b1;
    end
  end
  always @(posedge sys_clk_i)
    if (rd_valid_i && rd_ready_o)
      rq.push_back(rd_data_i);
endmodule
`default_nettype wire

// ---- sim/tb_top.sv ----
// self-checking bench for the dram command block
// assumes the controller model drives all device inputs except clock and reset, which come from this bench
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import dcm_pkg::*;
  logic sys_clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  dcm_pins_t pins_i;
  logic [DATA_W-1:0] wr_data_i, rd_data_o;
  logic wr_mask_i, wr_beat_o, rd_valid_o, rd_ready_i, self_refresh_o, dll_on_o, dll_locked_o;
  logic [NBANK-1:0] bank_open_o, bank_precharging_o;
  logic [ROW_W-1:0] refresh_row_o;
  logic [7:0] exp[8];
  int n_errors = 0;
  int checks = 0;
  always #50 sys_clk_i = ~sys_clk_i;
  dcm_dram_core dcm_dram_core_i (.sys_clk_i, .rst_b_i, .pins_i, .wr_data_i, .wr_mask_i, .wr_beat_o, .rd_data_o,
    .rd_valid_o, .rd_ready_i, .bank_open_o, .bank_precharging_o, .self_refresh_o, .dll_on_o, .dll_locked_o,
    .refresh_row_o);
  dcm_ctl_model dcm_ctl_model_i (.sys_clk_i, .pins_o(pins_i), .wr_data_o(wr_data_i), .wr_mask_o(wr_mask_i),
    .wr_beat_i(wr_beat_o), .rd_data_i(rd_data_o), .rd_valid_i(rd_valid_o), .rd_ready_o(rd_ready_i));
  task automatic cmp(input string what, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e)
    begin
      $display("CHECK FAILED %s expected %h seen %h", what, e, g);
      n_errors++;
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask
  task automatic wr(input logic [2:0] b, input logic [13:0] a, input logic [7:0] base, input int n, input int mk);
    for (int k = 0; k < n; k++)
    begin
      dcm_ctl_model_i.wq.push_back(base + 8'(k));
      dcm_ctl_model_i.mq.push_back(k == mk);
    end
    dcm_ctl_model_i.issue(CMD_WRITE, b, a);
    idle(14);
  endtask
  // read with the consumer stalled, then drained
  task automatic rd_chk(input logic [2:0] b, input logic [13:0] a, input int n);
    int w;
    dcm_ctl_model_i.rq.delete();
    dcm_ctl_model_i.issue(CMD_READ, b, a);
    idle(20);
    dcm_ctl_model_i.rd_ready_o = 1'b1;
    w = 0;
    while (dcm_ctl_model_i.rq.size() < n && w < 30)
    begin
      idle(1);
      w++;
    end
    dcm_ctl_model_i.rd_ready_o = 1'b0;
    for (int k = 0; k < n; k++)
      cmp("read beat", exp[k], dcm_ctl_model_i.rq[k]);
    cmp("fifo empty", 8'h00, {7'h00, rd_valid_o});
  endtask
  task automatic t_reset;
    cmp("bank open", 8'h00, bank_open_o);
    cmp("dll on", 8'h01, {7'h00, dll_on_o});
    $display("test reset done");
  endtask
  task automatic t_rw4;
    dcm_ctl_model_i.issue(CMD_ACTIVATE, 3'h2, 14'h0005);
    cmp("bank open", 8'h04, bank_open_o);
    wr(3'h2, 14'h0000, 8'h10, 4, 9);
    wr(3'h2, 14'h0001, 8'h20, 4, 1);
    exp = '{8'h12, 8'h22, 8'h23, 8'h20, 8'h00, 8'h00, 8'h00, 8'h00};
    rd_chk(3'h2, 14'h0002, 4);
    cmp("bank open", 8'h04, bank_open_o);
    $display("test burst four done");
  endtask
  task automatic t_bl8;
    dcm_ctl_model_i.issue(CMD_PRECHARGE, 3'h0, 14'h0400);
    cmp("bank open", 8'h00, bank_open_o);
    dcm_ctl_model_i.issue(CMD_LOAD_MODE, 3'h0, 14'h003B);
    idle(2);
    dcm_ctl_model_i.issue(CMD_ACTIVATE, 3'h2, 14'h0005);
    wr(3'h2, 14'h0003, 8'h30, 8, 9);
    for (int k = 0; k < 8; k++)
      exp[k] = 8'h30 + 8'(3'h5 ^ 3'(k) ^ 3'h3);
    rd_chk(3'h2, 14'h0405, 8);
    idle(4);
    cmp("bank open", 8'h00, bank_open_o);
    $display("test burst eight done");
  endtask
  task automatic t_pre;
    dcm_ctl_model_i.issue(CMD_ACTIVATE, 3'h4, 14'h0001);
    cmp("bank open", 8'h10, bank_open_o);
    dcm_ctl_model_i.issue(CMD_PRECHARGE, 3'h4, 14'h0000);
    cmp("bank open", 8'h00, bank_open_o);
    dcm_ctl_model_i.issue(CMD_PRECHARGE, 3'h4, 14'h0000);
    cmp("bank open", 8'h00, bank_open_o);
    dcm_ctl_model_i.issue(4'hB, 3'h4, 14'h0001);
    cmp("bank open", 8'h00, bank_open_o);
    $display("test precharge done");
  endtask
  task automatic t_ref;
    dcm_ctl_model_i.issue(CMD_REFRESH, 3'h5, 14'h2AAA);
    cmp("refresh row", 8'h01, {4'h0, refresh_row_o});
    dcm_ctl_model_i.cke_idle = 1'b0;
    dcm_ctl_model_i.issue(CMD_REFRESH, 3'h0, 14'h0000);
    cmp("self refresh", 8'h01, {7'h00, self_refresh_o});
    cmp("dll on", 8'h00, {7'h00, dll_on_o});
    dcm_ctl_model_i.cke_idle = 1'b1;
    dcm_ctl_model_i.issue(CMD_NOP, 3'h0, 14'h0000);
    cmp("self refresh", 8'h00, {7'h00, self_refresh_o});
    cmp("dll relocking", 8'h02, {6'h00, dll_on_o, dll_locked_o});
    idle(200);
    cmp("dll locked", 8'h03, {6'h00, dll_on_o, dll_locked_o});
    $display("test refresh done");
  endtask
  task stop_test;
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial
  begin
    #300000;
    n_errors++;
    stop_test;
  end
  initial
  begin
    repeat (5) @(posedge sys_clk_i);
    #1;
    rst_b_i = 1'b1;
    t_reset;
    t_rw4;
    t_bl8;
    t_pre;
    t_ref;
    stop_test;
  end
endmodule
`default_nettype wire
